// >>> verilog/pwr_rst_auth_defs.svh
`ifndef PWR_RST_AUTH_DEFS_SVH
`define PWR_RST_AUTH_DEFS_SVH

// ----------------------------------------------------------------
// register offsets, byte addresses
// ----------------------------------------------------------------
`define DPC_BASE 12'hA00
`define DPS_BASE 12'hA80
`define SYS_PCR_BASE 12'hB00
`define SYS_PSR_BASE 12'hB80
`define DBG_RST_REQ_OFS 12'hC10
`define DBG_RST_ACK_OFS 12'hC14
`define SYS_RST_REQ_OFS 12'hC18
`define SYS_RST_ACK_OFS 12'hC1C
`define AUTH_STATUS_OFS 12'hFB8
`define CID0_OFS 12'hFF0
`define CID1_OFS 12'hFF4
`define CID2_OFS 12'hFF8
`define CID3_OFS 12'hFFC

// ----------------------------------------------------------------
// domain counts and field layout
// ----------------------------------------------------------------
`define NUM_DOMAINS 32
`define PCR_REQ_BIT 1
`define PCR_IMPL_BIT 0
`define PS_UNPOWERED 2'h0
`define PS_HELD 2'h3
`define AUTH_ENABLED 2'h3
`define AUTH_DISABLED 2'h2
`define AUTH_UNSUPP 2'h0

// ----------------------------------------------------------------
// identification bytes, values arbitrary
// ----------------------------------------------------------------
`define IDENT_BYTE_ZERO 8'h5A
`define IDENT_BYTE_ONE_LO 4'h3
`define IDENT_CLASS 4'hC
`define IDENT_BYTE_TWO 8'h6E
`define IDENT_BYTE_THREE 8'hA7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define DBG_RST_PULSE_NS 80
`define DBG_RST_PULSE_CYC \
   ((`DBG_RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> verilog/pwr_rst_auth_pkg.sv
`default_nettype none

package pwr_rst_auth_pkg;
   // per-domain power handshake state
   typedef enum logic [1:0] {
      PD_IDLE,
      PD_WAIT_ACK,
      PD_HELD,
      PD_WAIT_DROP
   } pd_state_t;

   // reset handshake state
   typedef enum logic [1:0] {
      RS_IDLE,
      RS_ASSERT,
      RS_DONE
   } rst_state_t;
endpackage

`default_nettype wire

// >>> verilog/power_domain_ctl.sv
`include "pwr_rst_auth_defs.svh"
`default_nettype none

module power_domain_ctl
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic allow_i,
   input wire logic ack_raw_i,
   output logic pwr_req_o,
   output logic [1:0] state_field_o
);
   pwr_rst_auth_pkg::pd_state_t st_reg;
   pwr_rst_auth_pkg::pd_state_t st_next;
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic ack_reg;
   wire logic ack_agree;

   // ----------------------------------------------------------------
   // acknowledge synchroniser, change taken when stages agree
   // ----------------------------------------------------------------
   assign ack_agree = (s2_reg == s3_reg);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         ack_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= ack_raw_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (ack_agree)
            ack_reg <= s3_reg;
      end
   end

   // ----------------------------------------------------------------
   // four-phase handshake
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      unique case (st_reg)
         pwr_rst_auth_pkg::PD_IDLE:
            if (req_i && allow_i)
               st_next = pwr_rst_auth_pkg::PD_WAIT_ACK;
         pwr_rst_auth_pkg::PD_WAIT_ACK:
            if (!req_i)
               st_next = pwr_rst_auth_pkg::PD_WAIT_DROP;
            else if (ack_reg)
               st_next = pwr_rst_auth_pkg::PD_HELD;
         pwr_rst_auth_pkg::PD_HELD:
            if (!req_i)
               st_next = pwr_rst_auth_pkg::PD_WAIT_DROP;
         pwr_rst_auth_pkg::PD_WAIT_DROP:
            if (!ack_reg)
               st_next = pwr_rst_auth_pkg::PD_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg <= pwr_rst_auth_pkg::PD_IDLE;
         pwr_req_o <= 1'b0;
         state_field_o <= `PS_UNPOWERED;
      end
      else
      begin
         st_reg <= st_next;
         pwr_req_o <= (st_next == pwr_rst_auth_pkg::PD_WAIT_ACK) ||
                      (st_next == pwr_rst_auth_pkg::PD_HELD);
         // held shown only once power came, kept until it goes
         state_field_o <= (st_next == pwr_rst_auth_pkg::PD_HELD ||
                           (st_next == pwr_rst_auth_pkg::PD_WAIT_DROP &&
                            state_field_o == `PS_HELD))
                          ? `PS_HELD : `PS_UNPOWERED;
      end
   end
endmodule

`default_nettype wire

// >>> verilog/debug_power_reset_auth_table.sv
// What this block does
// - manage up to 32 debug and 32 system reset domains.
// - system held in reset while system reset request bit is set.
// - debug logic reset only briefly, released while system stays in reset.
// - power requests ignored when all debug functions are disabled.
// - power requests ignored while noninvasive and invasive debug are both disabled.
// - with secure split, resets ignored when secure invasive disabled.
// - without secure split, resets ignored when invasive disabled.
// - without split, secure fields mirror the non-secure fields.
// - secure noninvasive field from secure and general enables.
// - secure invasive field needs secure invasive and invasive enable.
// - non-secure noninvasive field from noninvasive or invasive enable.
// - non-secure invasive field follows invasive enable; upper bits zero.
// - four read-only identification bytes; class in second, bits 7:4.
// - status field: 00 unpowered, 01 powered, 11 held, 10 reserved.
// - control bit 1 is request, bit 0 read-only implemented flag.
// - status goes held after request, back to 00 after withdrawal.
`include "pwr_rst_auth_defs.svh"
`default_nettype none

module debug_power_reset_auth_table
#(
   parameter bit SECURE_SPLIT = 1'b1
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [11:2] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic invasive_enable_i,
   input wire logic noninvasive_enable_i,
   input wire logic secure_invasive_enable_i,
   input wire logic secure_noninvasive_enable_i,
   output logic [31:0] debug_powerup_request_o,
   input wire logic [31:0] debug_powerup_ack_i,
   output logic [31:0] sys_powerup_request_o,
   input wire logic [31:0] sys_powerup_ack_i,
   output logic [31:0] debug_reset_o,
   input wire logic [31:0] debug_reset_done_i,
   output logic [31:0] system_reset_o,
   input wire logic [31:0] system_reset_done_i
);
   localparam int N = `NUM_DOMAINS;
   localparam int PULSE = `DBG_RST_PULSE_CYC;

   // request and ack bits
   logic [31:0] dpc_req_reg;
   logic [31:0] spc_req_reg;
   logic [31:0] drr_reg;
   logic [31:0] dra_reg;
   logic [31:0] srr_reg;
   logic [31:0] sra_reg;
   // sync stages
   logic [3:0] en_s1_reg;
   logic [3:0] en_s2_reg;
   logic [3:0] en_s3_reg;
   logic [3:0] en_reg;
   logic [31:0] dd_s1_reg;
   logic [31:0] dd_s2_reg;
   logic [31:0] dd_s3_reg;
   logic [31:0] dd_reg;
   logic [31:0] sd_s1_reg;
   logic [31:0] sd_s2_reg;
   logic [31:0] sd_s3_reg;
   logic [31:0] sd_reg;
   // reset pulse counters
   logic [7:0] pulse_cnt_reg [N];
   wire logic [31:0] pulse_done;
   // engine requests, status
   wire logic [31:0] dbg_pwr_req;
   wire logic [31:0] sys_pwr_req;
   wire logic [1:0] dps [N];
   wire logic [1:0] sps [N];

   // ----------------------------------------------------------------
   // enable synchroniser, order dbg, noninvasive_enable, secure_invasive_enable, secure_noninvasive_enable
   // ----------------------------------------------------------------
   wire logic [3:0] en_raw = {secure_noninvasive_enable_i,
                              secure_invasive_enable_i,
                              noninvasive_enable_i, invasive_enable_i};
   // agree mask per bit
   wire logic [3:0] en_agree = ~(en_s2_reg ^ en_s3_reg);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         en_s1_reg <= 4'h0;
         en_s2_reg <= 4'h0;
         en_s3_reg <= 4'h0;
         en_reg <= 4'h0;
      end
      else
      begin
         en_s1_reg <= en_raw;
         en_s2_reg <= en_s1_reg;
         en_s3_reg <= en_s2_reg;
         en_reg <= (en_s3_reg & en_agree) |
                   (en_reg & ~en_agree);
      end
   end

   // ----------------------------------------------------------------
   // reset-done synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dd_s1_reg <= 32'h0;
         dd_s2_reg <= 32'h0;
         dd_s3_reg <= 32'h0;
         dd_reg <= 32'h0;
         sd_s1_reg <= 32'h0;
         sd_s2_reg <= 32'h0;
         sd_s3_reg <= 32'h0;
         sd_reg <= 32'h0;
      end
      else
      begin
         // debug domains
         dd_s1_reg <= debug_reset_done_i;
         dd_s2_reg <= dd_s1_reg;
         dd_s3_reg <= dd_s2_reg;
         dd_reg <= (dd_s2_reg == dd_s3_reg) ? dd_s3_reg : dd_reg;
         // system domains
         sd_s1_reg <= system_reset_done_i;
         sd_s2_reg <= sd_s1_reg;
         sd_s3_reg <= sd_s2_reg;
         sd_reg <= (sd_s2_reg == sd_s3_reg) ? sd_s3_reg : sd_reg;
      end
   end

   // ----------------------------------------------------------------
   // authentication decode
   // ----------------------------------------------------------------
   wire logic dbg_en = en_reg[0];
   wire logic nid_en = en_reg[1];
   wire logic sid_en = en_reg[2];
   wire logic secure_noninvasive_field_en = en_reg[3];
   // field enable terms
   wire logic nonsecure_invasive_field_on = dbg_en;
   wire logic nonsecure_noninvasive_field_on = nid_en | dbg_en;
   wire logic sid_on = SECURE_SPLIT ?
                       (sid_en & dbg_en) : nonsecure_invasive_field_on;
   wire logic secure_noninvasive_field_on = SECURE_SPLIT ?
                        ((sid_en | secure_noninvasive_field_en) & (dbg_en | nid_en))
                        : nonsecure_noninvasive_field_on;
   // two-bit field codes
   wire logic [1:0] f_secure_noninvasive_field = secure_noninvasive_field_on ? `AUTH_ENABLED : `AUTH_DISABLED;
   wire logic [1:0] f_sid = sid_on ? `AUTH_ENABLED : `AUTH_DISABLED;
   wire logic [1:0] f_nonsecure_noninvasive_field = nonsecure_noninvasive_field_on ? `AUTH_ENABLED : `AUTH_DISABLED;
   wire logic [1:0] f_nonsecure_invasive_field = nonsecure_invasive_field_on ? `AUTH_ENABLED : `AUTH_DISABLED;
   wire logic [31:0] auth_word = {24'h0, f_secure_noninvasive_field, f_sid, f_nonsecure_noninvasive_field,
                                  f_nonsecure_invasive_field};
   // power needs noninvasive debug; reset needs (secure) invasive
   wire logic pwr_allow = nonsecure_noninvasive_field_on;
   wire logic rst_allow = SECURE_SPLIT ? sid_on
                                       : nonsecure_invasive_field_on;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire logic [11:0] addr = {adr_i, 2'b00};
   wire logic [4:0] idx = adr_i[6:2];
   wire logic req_go = cyc_i & stb_i & ~ack_o;
   wire logic wr_go = req_go & we_i & sel_i[0];
   // array windows, then singles
   wire logic hit_dpc = (addr & 12'hF80) == `DPC_BASE;
   wire logic hit_dps = (addr & 12'hF80) == `DPS_BASE;
   wire logic hit_spc = (addr & 12'hF80) == `SYS_PCR_BASE;
   wire logic hit_sps = (addr & 12'hF80) == `SYS_PSR_BASE;
   wire logic hit_drr = addr == `DBG_RST_REQ_OFS;
   wire logic hit_dra = addr == `DBG_RST_ACK_OFS;
   wire logic hit_srr = addr == `SYS_RST_REQ_OFS;
   wire logic hit_sra = addr == `SYS_RST_ACK_OFS;
   wire logic hit_auth = addr == `AUTH_STATUS_OFS;
   // control and status words
   wire logic [31:0] dpc_word = {30'h0, dpc_req_reg[idx], 1'b1};
   wire logic [31:0] spc_word = {30'h0, spc_req_reg[idx], 1'b1};
   wire logic [31:0] dps_word = {30'h0, dps[idx]};
   wire logic [31:0] sps_word = {30'h0, sps[idx]};
   // identification words
   wire logic [31:0] id0_word = {24'h0, `IDENT_BYTE_ZERO};
   wire logic [31:0] id1_word = {24'h0, `IDENT_CLASS, `IDENT_BYTE_ONE_LO};
   wire logic [31:0] id2_word = {24'h0, `IDENT_BYTE_TWO};
   wire logic [31:0] id3_word = {24'h0, `IDENT_BYTE_THREE};
   // read mux, zero if unmapped
   wire logic [31:0] rd_word =
      hit_dpc ? dpc_word :
      hit_dps ? dps_word :
      hit_spc ? spc_word :
      hit_sps ? sps_word :
      hit_drr ? drr_reg :
      hit_dra ? dra_reg :
      hit_srr ? srr_reg :
      hit_sra ? sra_reg :
      hit_auth ? auth_word :
      (addr == `CID0_OFS) ? id0_word :
      (addr == `CID1_OFS) ? id1_word :
      (addr == `CID2_OFS) ? id2_word :
      (addr == `CID3_OFS) ? id3_word : 32'h0;

   // ----------------------------------------------------------------
   // bus answer, one wait-free cycle, reads side-effect free
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end
      else
      begin
         // answer one cycle later
         ack_o <= req_go;
         dat_o <= (req_go && !we_i) ? rd_word : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // power request bits
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dpc_req_reg <= 32'h0;
         spc_req_reg <= 32'h0;
      end
      else if (wr_go && hit_dpc)
         dpc_req_reg[idx] <= dat_i[`PCR_REQ_BIT];
      else if (wr_go && hit_spc)
         spc_req_reg[idx] <= dat_i[`PCR_REQ_BIT];
   end

   // gating sits in the engines
   assign dbg_pwr_req = dpc_req_reg;
   assign sys_pwr_req = spc_req_reg;

   // ----------------------------------------------------------------
   // per-domain power handshake engines
   // ----------------------------------------------------------------
   // one engine per domain
   for (genvar g = 0; g < N; g++)
   begin : g_pd
      power_domain_ctl u_dbg
      (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .req_i(dbg_pwr_req[g]),
         .allow_i(pwr_allow),
         .ack_raw_i(debug_powerup_ack_i[g]),
         .pwr_req_o(debug_powerup_request_o[g]),
         .state_field_o(dps[g])
      );
      power_domain_ctl u_sys
      (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .req_i(sys_pwr_req[g]),
         .allow_i(pwr_allow),
         .ack_raw_i(sys_powerup_ack_i[g]),
         .pwr_req_o(sys_powerup_request_o[g]),
         .state_field_o(sps[g])
      );
   end

   // ----------------------------------------------------------------
   // reset request/ack registers, 32 domains each
   // ----------------------------------------------------------------
   // set needs allow, clear free
   wire logic [31:0] drr_wr = dat_i &
                              {32{rst_allow}};
   wire logic [31:0] srr_wr = dat_i &
                              {32{rst_allow}};
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         drr_reg <= 32'h0;
         srr_reg <= 32'h0;
         dra_reg <= 32'h0;
         sra_reg <= 32'h0;
      end
      else
      begin
         if (wr_go && hit_drr)
            drr_reg <= drr_wr | (drr_reg & dat_i);
         if (wr_go && hit_srr)
            srr_reg <= srr_wr | (srr_reg & dat_i);
         // ack sets on completion, falls with request
         dra_reg <= drr_reg & (dra_reg | (pulse_done & dd_reg));
         sra_reg <= srr_reg & (sra_reg | sd_reg);
      end
   end

   // ----------------------------------------------------------------
   // debug reset pulse: short, released even under system reset
   // ----------------------------------------------------------------
   // pulse counter per domain
   for (genvar r = 0; r < N; r++)
   begin : g_rp
      assign pulse_done[r] = pulse_cnt_reg[r] == 8'(PULSE);
      always_ff @(posedge clk_i)
      begin
         if (rst_i || !drr_reg[r])
            pulse_cnt_reg[r] <= 8'h0;
         else if (!pulse_done[r])
            pulse_cnt_reg[r] <= pulse_cnt_reg[r] + 8'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         debug_reset_o <= 32'h0;
         system_reset_o <= 32'h0;
      end
      else
      begin
         // ends even under system reset
         debug_reset_o <= drr_reg & ~pulse_done;
         // held while its bit is set
         system_reset_o <= srr_reg;
      end
   end
endmodule

`default_nettype wire

// >>> verif/debug_power_reset_auth_table_assertions.sv
`default_nettype none

module debug_power_reset_auth_table_checker
#(
   parameter bit SECURE_SPLIT = 1'b1
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic invasive_enable_i,
   input wire logic noninvasive_enable_i,
   input wire logic secure_invasive_enable_i,
   input wire logic [31:0] debug_powerup_request_o,
   input wire logic [31:0] sys_powerup_request_o,
   input wire logic [31:0] debug_reset_o,
   input wire logic [31:0] system_reset_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // enable history
   // ------------------------------------------------------------
   wire logic rst_gate = invasive_enable_i &
      (secure_invasive_enable_i | ~SECURE_SPLIT);
   wire logic pwr_gate = invasive_enable_i | noninvasive_enable_i;
   logic [3:0] rst_off_cnt;
   logic [3:0] pwr_off_cnt;

   // cycles each gate has been low, saturating at 15
   always_ff @(posedge clk_i)
   begin
      if (rst_i || rst_gate)
         rst_off_cnt <= 4'h0;
      else if (rst_off_cnt != 4'hF)
         rst_off_cnt <= rst_off_cnt + 4'h1;
      if (rst_i || pwr_gate)
         pwr_off_cnt <= 4'h0;
      else if (pwr_off_cnt != 4'hF)
         pwr_off_cnt <= pwr_off_cnt + 4'h1;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack stood longer than one cycle");
   AST_ACK_ANSWER: assert property (
      cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not answered next cycle");
   AST_IDLE_DATA: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data driven outside an answer");
   AST_DBG_RST_PULSE: assert property ($rose(debug_reset_o[0]) |->
      debug_reset_o[0] [*8] ##1 !debug_reset_o[0])
      else $error("debug reset pulse not eight cycles");
   AST_DBG_RST_GATE: assert property ($rose(|debug_reset_o) |->
      rst_off_cnt < 4'h8)
      else $error("debug reset raised while invasive debug off");
   AST_SYS_RST_GATE: assert property ($rose(|system_reset_o) |->
      rst_off_cnt < 4'h8)
      else $error("system reset raised while invasive debug off");
   AST_DBG_PWR_GATE: assert property (
      $rose(|debug_powerup_request_o) |-> pwr_off_cnt < 4'h8)
      else $error("debug power asked while noninvasive debug off");
   AST_SYS_PWR_GATE: assert property (
      $rose(|sys_powerup_request_o) |-> pwr_off_cnt < 4'h8)
      else $error("system power asked while debug off");
   AST_SYS_RST_HOLD: assert property ($fell(system_reset_o[0]) |->
      ack_o || $past(ack_o))
      else $error("system reset dropped without a write");

   cover property ($rose(debug_reset_o[0]));
   cover property ($fell(system_reset_o[0]));
   cover property ($rose(|debug_powerup_request_o));
endmodule

bind debug_power_reset_auth_table debug_power_reset_auth_table_checker
   #(.SECURE_SPLIT(SECURE_SPLIT)) u_checker
(
   .clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o, .invasive_enable_i,
   .noninvasive_enable_i, .secure_invasive_enable_i,
   .debug_powerup_request_o, .sys_powerup_request_o, .debug_reset_o,
   .system_reset_o
);

`default_nettype wire

// >>> verif/power_reset_partner.sv
`default_nettype none

module power_reset_partner
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic [31:0] dbg_req_i,
   input wire logic [31:0] sys_req_i,
   input wire logic [31:0] dbg_rst_i,
   input wire logic [31:0] sys_rst_i,
   output logic [31:0] dbg_ack_o,
   output logic [31:0] sys_ack_o,
   output logic [31:0] dbg_done_o,
   output logic [31:0] sys_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0][31:0] dq;
   logic [7:0][31:0] sq;
   logic [7:0][31:0] rq;
   logic [31:0] seen;

   // delay lines model a quick or a sluggish controller
   always_ff @(posedge clk_i)
   begin
      dq <= {dq[6:0], dbg_req_i};
      sq <= {sq[6:0], sys_req_i};
      rq <= {rq[6:0], sys_rst_i};
      seen <= rst_i ? 32'h0 : (seen | dbg_rst_i);
   end

   // acks follow requests both ways, four-phase
   assign dbg_ack_o = slow_i ? dq[7] : dq[1];
   assign sys_ack_o = slow_i ? sq[7] : sq[1];
   // debug domain done once its pulse was seen
   assign dbg_done_o = seen;
   // system done while it is held in reset
   assign sys_done_o = slow_i ? rq[7] : rq[1];
endmodule

`default_nettype wire

// >>> verif/debug_power_reset_auth_table_bench.sv
`include "pwr_rst_auth_defs.svh"
`default_nettype none

module debug_power_reset_auth_table_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, slow;
   logic [11:2] adr_i;
   logic [11:0] a;
   logic [3:0] sel_i, en, v;
   logic [31:0] dat_i, dat_o, q, r, m, dpr, dpa, spr, spa, drs, dds, srs, sds;
   logic [7:0] ids [4] = '{`IDENT_BYTE_ZERO, {`IDENT_CLASS, `IDENT_BYTE_ONE_LO},
      `IDENT_BYTE_TWO, `IDENT_BYTE_THREE};
   logic [31:0] q2, dat_flat;
   int fails = 0, compares = 0, cyc_cnt = 0, i, d;

   debug_power_reset_auth_table u_dut
   (
      .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .invasive_enable_i(en[0]), .noninvasive_enable_i(en[1]),
      .secure_invasive_enable_i(en[2]), .secure_noninvasive_enable_i(en[3]),
      .debug_powerup_request_o(dpr), .debug_powerup_ack_i(dpa),
      .sys_powerup_request_o(spr), .sys_powerup_ack_i(spa),
      .debug_reset_o(drs), .debug_reset_done_i(dds),
      .system_reset_o(srs), .system_reset_done_i(sds)
   );

   // flat-world copy: secure fields mirror the non-secure ones
   debug_power_reset_auth_table #(.SECURE_SPLIT(1'b0)) u_flat
   (
      .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o(dat_flat), .ack_o(), .invasive_enable_i(en[0]),
      .noninvasive_enable_i(en[1]), .secure_invasive_enable_i(en[2]),
      .secure_noninvasive_enable_i(en[3]), .debug_powerup_request_o(),
      .debug_powerup_ack_i('0), .sys_powerup_request_o(),
      .sys_powerup_ack_i('0), .debug_reset_o(), .debug_reset_done_i('0),
      .system_reset_o(), .system_reset_done_i('0)
   );

   power_reset_partner u_far
   (
      .clk_i, .rst_i, .slow_i(slow), .dbg_req_i(dpr), .sys_req_i(spr),
      .dbg_rst_i(drs), .sys_rst_i(srs), .dbg_ack_o(dpa), .sys_ack_o(spa),
      .dbg_done_o(dds), .sys_done_o(sds)
   );

   // ------------------------------------------------------------
   // clock, timeout, helpers
   // ------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000)
      begin
         fails = fails + 1;
         results();
      end
   end

   // expected status word from {sec nonInv, sec inv, nonInv, inv}, split s
   function automatic logic [31:0] auth_exp(input logic [3:0] e,
      input bit s);
      logic secure_noninvasive_field, secure_invasive_field, nonsecure_noninvasive_field;
      nonsecure_noninvasive_field = e[0] | e[1];
      secure_noninvasive_field = s ? (e[2] | e[3]) & nonsecure_noninvasive_field : nonsecure_noninvasive_field;
      secure_invasive_field = s ? e[2] & e[0] : e[0];
      return {24'h0, 1'b1, secure_noninvasive_field, 1'b1, secure_invasive_field, 1'b1, nonsecure_noninvasive_field, 1'b1, e[0]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic results();
      if (fails == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [11:0] ad,
      input logic [31:0] wd);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= ad[11:2];
      dat_i <= wd;
      do
         @(posedge clk_i);
      while (ack_o !== 1'b1);
      q = dat_o;
      q2 = dat_flat;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic poll(input logic [11:0] ad, input logic [31:0] e);
      int n;
      n = 0;
      do
      begin
         wb(1'b0, ad, 32'h0);
         n++;
      end
      while (q !== e && n < 60);
      chk("polled status", e, q);
   endtask

   task automatic set_en(input logic [3:0] e);
      en <= e;
      repeat (8) @(posedge clk_i);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      slow = 1'b0;
      adr_i = 10'h000;
      sel_i = 4'hF;
      dat_i = 32'h0;
      en = 4'h0;
      rst_i = 1'b1;
      r = $urandom(32'h0A43F10C);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // identification bytes ignore writes
      for (i = 0; i < 4; i++)
      begin
         a = 12'(`CID0_OFS + 4 * i);
         wb(1'b1, a, $urandom());
         wb(1'b0, a, 32'h0);
         chk("ident", {24'h0, ids[i]}, q);
      end
      wb(1'b1, 12'h100, $urandom());
      wb(1'b0, 12'h100, 32'h0);
      chk("unmapped", 32'h0, q);
      // all enable combinations in shuffled order
      r = $urandom();
      for (i = 0; i < 16; i++)
      begin
         v = 4'(i) ^ r[3:0];
         set_en(v);
         wb(1'b0, `AUTH_STATUS_OFS, 32'h0);
         chk("auth", auth_exp(v, 1), q);
         chk("auth flat", auth_exp(v, 0), q2);
      end
      // power handshake: debug fast, system slow at top domain
      set_en(4'h3);
      for (i = 0; i < 2; i++)
      begin
         slow <= i[0];
         d = (i == 1) ? 31 : int'($urandom_range(30, 0));
         a = 12'(((i == 1) ? `SYS_PCR_BASE : `DPC_BASE) + 4 * d);
         wb(1'b0, a, 32'h0);
         chk("control", 32'h1, q);
         poll(a + 12'h080, 32'h0);
         wb(1'b1, a, 32'h2);
         poll(a + 12'h080, 32'h3);
         chk("request", 32'h1 << d, (i == 1) ? spr : dpr);
         wb(1'b1, a, 32'h0);
         poll(a + 12'h080, 32'h0);
         chk("request off", 32'h0, (i == 1) ? spr : dpr);
      end
      // debug off: bit kept, no power asked
      set_en(4'h0);
      a = 12'(`DPC_BASE + 4 * d);
      wb(1'b1, a, 32'h2);
      repeat (20) @(posedge clk_i);
      chk("gated", 32'h0, dpr);
      wb(1'b0, a + 12'h080, 32'h0);
      chk("gated status", 32'h0, q);
      wb(1'b1, a, 32'h0);
      // secure invasive off: reset request refused
      set_en(4'h3);
      wb(1'b1, `SYS_RST_REQ_OFS, 32'h1);
      repeat (20) @(posedge clk_i);
      chk("refused", 32'h0, srs);
      wb(1'b0, `SYS_RST_REQ_OFS, 32'h0);
      chk("refused bit", 32'h0, q);
      // debug resets pulse while system held
      set_en(4'hF);
      wb(1'b1, `SYS_RST_REQ_OFS, 32'h1);
      poll(`SYS_RST_ACK_OFS, 32'h1);
      chk("system held", 32'h1, srs);
      for (i = 0; i < 2; i++)
      begin
         m = 32'h1 << (31 * i);
         wb(1'b1, `DBG_RST_REQ_OFS, m);
         poll(`DBG_RST_ACK_OFS, m);
         chk("debug released", 32'h0, drs);
         wb(1'b1, `DBG_RST_REQ_OFS, 32'h0);
         poll(`DBG_RST_ACK_OFS, 32'h0);
      end
      chk("system still held", 32'h1, srs);
      wb(1'b1, `SYS_RST_REQ_OFS, 32'h0);
      poll(`SYS_RST_ACK_OFS, 32'h0);
      chk("system free", 32'h0, srs);
      // reset in mid-handshake
      wb(1'b1, a, 32'h2);
      poll(a + 12'h080, 32'h3);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("reset request", 32'h0, dpr);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, a, 32'h0);
      chk("reset control", 32'h1, q);
      results();
   end
endmodule

`default_nettype wire
